// [core/motor_gate_pkg.sv]
// Constants, register map and carrier types shared by the motor gate output stage.
package motor_gate_pkg;

  // Byte offsets on the APB register bus.
  localparam logic [7:0] OFS_MASK_CTRL = 8'h00;
  localparam logic [7:0] OFS_MONITOR = 8'h04;
  localparam logic [7:0] OFS_MASK_EN = 8'h08;
  localparam logic [7:0] OFS_MASK_DATA = 8'h0c;
  localparam logic [7:0] OFS_DEAD_TIME = 8'h10;
  localparam logic [7:0] OFS_POLARITY = 8'h14;
  localparam logic [7:0] OFS_HALL_CTRL = 8'h18;
  localparam logic [7:0] OFS_SOFT_HALL = 8'h1c;
  localparam logic [7:0] OFS_FILTER_CTRL = 8'h20;
  localparam logic [7:0] OFS_PIN_FUNC = 8'h24;
  localparam logic [7:0] OFS_DECODE_BASE = 8'h40;
  localparam logic [7:0] OFS_DECODE_LAST = 8'h6c;
  localparam int DECODE_ENTRIES = 12;
  localparam int FORWARD_ENTRIES = 6;

  // Values after reset.
  localparam logic [7:0] RST_MASK_CTRL = 8'h04;
  localparam logic [7:0] RST_HALL_CTRL = 8'h10;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [31:0] RST_PIN_FUNC = 32'h00000000;

  // Field positions.
  localparam int MC_MASK_MODE_BIT = 7;
  localparam int MC_NONCOMP_BIT = 3;
  localparam int MC_PWM_EN_BIT = 2;
  localparam int MC_PROTECT_SEL_BIT = 1;
  localparam int MC_TOP_SEL_BIT = 0;
  localparam int DT_DIV_LSB = 6;
  localparam int DT_ENABLE_BIT = 5;
  localparam int HC_DECODER_EN_BIT = 0;
  localparam int HC_DIR_BIT = 1;
  localparam int HC_BRAKE_BIT = 2;
  localparam int HC_SOURCE_BIT = 3;
  localparam int HC_ANGLE_BIT = 4;
  localparam int FILTER_EN_BIT = 0;
  localparam int PF_GPIO_SEL_LSB = 0;
  localparam int PF_GPIO_DATA_LSB = 8;
  localparam int PF_DRIVE_LSB = 16;

  // Filter cycle count and brake decode word.
  localparam logic [2:0] FILTER_SAMPLES = 3'h4;
  localparam logic [5:0] BRAKE_DECODE = 6'h15;

  typedef enum logic [2:0] {
    DT_LOW = 3'b001,
    DT_WAIT = 3'b010,
    DT_HIGH = 3'b100
  } dead_state_e;

  typedef struct packed {
    logic mask_mode_select;
    logic hw_complement_select;
    logic pwm_output_enable;
    logic protect_output_select;
    logic top_bottom_pwm_select;
  } mask_ctrl_s;

  typedef struct packed {
    logic [1:0] deadtime_clock_divide;
    logic deadtime_enable;
    logic [4:0] count;
  } dead_time_s;

endpackage

// [core/hall_input_front.sv]
// Hall sensor input synchroniser, noise filter with bypass, and source select.
`timescale 1ns/1ps
module hall_input_front (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] hall_pins,
  input wire logic [2:0] soft_hall,
  input wire logic hall_source_mode,
  input wire logic hall_filter_enable,
  output logic [2:0] filtered_hall,
  output logic [2:0] hall_out
);
  logic [2:0] sync1_q, sync2_q, sync3_q, accepted_q, filt_q;
  logic [2:0] agree_cnt_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      accepted_q <= 3'h0;
    end else begin
      sync1_q <= hall_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        accepted_q <= sync3_q;
      end
    end
  end

  // A new level must persist for several samples before the filter follows it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filt_q <= 3'h0;
      agree_cnt_q <= 3'h0;
    end else if (accepted_q == filt_q) begin
      agree_cnt_q <= 3'h0;
    end else if (agree_cnt_q == motor_gate_pkg::FILTER_SAMPLES) begin
      filt_q <= accepted_q;
      agree_cnt_q <= 3'h0;
    end else begin
      agree_cnt_q <= agree_cnt_q + 3'h1;
    end
  end

  assign filtered_hall = hall_filter_enable ? filt_q : accepted_q;
  assign hall_out = hall_source_mode ? filtered_hall : soft_hall;
endmodule // hall_input_front

// [core/dead_time_channel.sv]
// One dead-time insertion channel: delays rising edges, passes falling edges.
`timescale 1ns/1ps
module dead_time_channel (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic enable,
  input wire logic [4:0] count,
  input wire logic din,
  output logic dout
);
  motor_gate_pkg::dead_state_e state_q;
  logic [5:0] cnt_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= motor_gate_pkg::DT_LOW;
      cnt_q <= 6'h00;
      dout <= 1'b0;
    end else if (!enable) begin
      dout <= din;
      state_q <= din ? motor_gate_pkg::DT_HIGH : motor_gate_pkg::DT_LOW;
      cnt_q <= 6'h00;
    end else begin
      case (state_q)
        motor_gate_pkg::DT_LOW: begin
          dout <= 1'b0;
          if (din) begin
            state_q <= motor_gate_pkg::DT_WAIT;
            cnt_q <= {1'b0, count} + 6'h01;
          end
        end
        motor_gate_pkg::DT_WAIT: begin
          if (!din) begin
            state_q <= motor_gate_pkg::DT_LOW;
          end else if (tick) begin
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
              state_q <= motor_gate_pkg::DT_HIGH;
              dout <= 1'b1;
            end
          end
        end
        motor_gate_pkg::DT_HIGH: begin
          if (!din) begin
            state_q <= motor_gate_pkg::DT_LOW;
            dout <= 1'b0;
          end
        end
        default: begin
          state_q <= motor_gate_pkg::DT_LOW;
          dout <= 1'b0;
        end
      endcase
    end
  end
endmodule // dead_time_channel

// [core/motor_gate_output_stage.sv]
// Motor gate output stage: decode, masking, overrides, dead time, stagger, polarity.
//
// Notes on behaviour
// - Bit 7 picks hardware or software masking.
// - Bit 3 picks complementary drive in hardware.
// - Bit 2 allows PWM on premask outputs.
// - Bit 0 routes PWM to bottom or top.
// - Monitor shows three gates and filtered Halls.
// - Complementary hardware decode per phase table.
// - Non-complementary decode drops the inverted wave.
// - Software mask enable substitutes mask data bit.
// - Both masked high in pair gives zeros.
// - Masked partner of PWM output forced low.
// - GPIO-configured pins ignore all masking.
// - Brake: tops low, bottoms high, overrides masking and protect.
// - Protect: tops low, bottoms per select bit.
// - Dead time delays rising edges only.
// - Dead-time enable bit switches insertion.
// - Dead-time clock divides by 1,2,4,8.
// - Dead time is count plus one periods.
// - Stagger forces both off when both high.
// - Polarity bit per output inverts it.
// - Hall source: sensor path or software bits.
// - Filter disabled means Halls bypass it.
// - Decode comes from forward or backward tables.
`timescale 1ns/1ps
module motor_gate_output_stage (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwm_true_wave,
  input wire logic pwm_inverted_wave,
  input wire logic protect_active,
  input wire logic [2:0] hall_pins,
  output logic gate_a_top,
  output logic gate_a_bottom,
  output logic gate_b_top,
  output logic gate_b_bottom,
  output logic gate_c_top,
  output logic gate_c_bottom,
  output logic [5:0] gate_oe
);

  logic [7:0] mask_ctrl_q, mask_en_q, mask_data_q, dead_time_q, polarity_q;
  logic [7:0] hall_ctrl_q, soft_hall_q, filter_ctrl_q;
  logic [31:0] pin_func_q;
  logic [5:0] decode_table_q [motor_gate_pkg::DECODE_ENTRIES];
  logic [5:0] premask_d, premask_q, dead_out, gate_d, gate_q;
  logic [2:0] prescale_q;
  logic [2:0] hall_in, filtered_hall;
  logic [31:0] rdata_d;
  logic rd_err_d;
  logic tick;
  logic access_wr;
  motor_gate_pkg::mask_ctrl_s mc;
  motor_gate_pkg::dead_time_s dt;

  assign mc = '{mask_mode_select: mask_ctrl_q[motor_gate_pkg::MC_MASK_MODE_BIT],
                hw_complement_select: mask_ctrl_q[motor_gate_pkg::MC_NONCOMP_BIT],
                pwm_output_enable: mask_ctrl_q[motor_gate_pkg::MC_PWM_EN_BIT],
                protect_output_select: mask_ctrl_q[motor_gate_pkg::MC_PROTECT_SEL_BIT],
                top_bottom_pwm_select: mask_ctrl_q[motor_gate_pkg::MC_TOP_SEL_BIT]};
  assign dt = dead_time_q;

  // Table offsets are decoded both for writes and for reads.
  function automatic logic is_table(input logic [7:0] addr);
    is_table = (addr >= motor_gate_pkg::OFS_DECODE_BASE) &&
               (addr <= motor_gate_pkg::OFS_DECODE_LAST) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] table_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - motor_gate_pkg::OFS_DECODE_BASE;
    table_index = rel[5:2];
  endfunction

  // Maps the Hall state to a step number; 7 marks an illegal state.
  function automatic logic [2:0] hall_step(input logic [2:0] h, input logic wide_angle);
    logic [2:0] sabc;
    sabc = {h[0], h[1], h[2]};
    case (sabc)
      3'b100: hall_step = 3'h0;
      3'b110: hall_step = 3'h1;
      3'b111: hall_step = wide_angle ? 3'h7 : 3'h2;
      3'b010: hall_step = wide_angle ? 3'h2 : 3'h7;
      3'b011: hall_step = 3'h3;
      3'b001: hall_step = 3'h4;
      3'b000: hall_step = wide_angle ? 3'h7 : 3'h5;
      3'b101: hall_step = wide_angle ? 3'h5 : 3'h7;
      default: hall_step = 3'h7;
    endcase
  endfunction

  // Hardware mask decode for one phase, result is {upper, lower}.
  function automatic logic [1:0] hw_pair(input logic up, input logic lo,
                                         input logic top_sel, input logic noncomp,
                                         input logic p, input logic pb);
    case ({up, lo})
      2'b01: hw_pair = top_sel ? 2'b01 : {noncomp ? 1'b0 : pb, p};
      2'b10: hw_pair = top_sel ? {p, noncomp ? 1'b0 : pb} : 2'b10;
      default: hw_pair = 2'b00;
    endcase
  endfunction

  hall_input_front u_hall (
    .clk(clk),
    .reset(reset),
    .hall_pins(hall_pins),
    .soft_hall(soft_hall_q[2:0]),
    .hall_source_mode(hall_ctrl_q[motor_gate_pkg::HC_SOURCE_BIT]),
    .hall_filter_enable(filter_ctrl_q[motor_gate_pkg::FILTER_EN_BIT]),
    .filtered_hall(filtered_hall),
    .hall_out(hall_in)
  );

  // APB: answer is prepared in the setup cycle so the access phase has no wait state.
  assign access_wr = psel && penable && pwrite && pready;

  always_comb begin
    rdata_d = 32'h00000000;
    rd_err_d = 1'b0;
    if (is_table(paddr)) begin
      rdata_d = {26'h0, decode_table_q[table_index(paddr)]};
    end else begin
      case (paddr)
        motor_gate_pkg::OFS_MASK_CTRL: rdata_d = {24'h000000, mask_ctrl_q};
        motor_gate_pkg::OFS_MONITOR: rdata_d = {26'h0, gate_q[0], gate_q[1],
                                                gate_q[2], filtered_hall};
        motor_gate_pkg::OFS_MASK_EN: rdata_d = {24'h000000, mask_en_q};
        motor_gate_pkg::OFS_MASK_DATA: rdata_d = {24'h000000, mask_data_q};
        motor_gate_pkg::OFS_DEAD_TIME: rdata_d = {24'h000000, dead_time_q};
        motor_gate_pkg::OFS_POLARITY: rdata_d = {24'h000000, polarity_q};
        motor_gate_pkg::OFS_HALL_CTRL: rdata_d = {24'h000000, hall_ctrl_q};
        motor_gate_pkg::OFS_SOFT_HALL: rdata_d = {24'h000000, soft_hall_q};
        motor_gate_pkg::OFS_FILTER_CTRL: rdata_d = {24'h000000, filter_ctrl_q};
        motor_gate_pkg::OFS_PIN_FUNC: rdata_d = pin_func_q;
        default: rd_err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= rd_err_d || (pwrite && paddr == motor_gate_pkg::OFS_MONITOR);
        prdata <= pwrite ? 32'h00000000 : rdata_d;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_ctrl_q <= motor_gate_pkg::RST_MASK_CTRL;
      mask_en_q <= motor_gate_pkg::RST_ZERO8;
      mask_data_q <= motor_gate_pkg::RST_ZERO8;
      dead_time_q <= motor_gate_pkg::RST_ZERO8;
      polarity_q <= motor_gate_pkg::RST_ZERO8;
      hall_ctrl_q <= motor_gate_pkg::RST_HALL_CTRL;
      soft_hall_q <= motor_gate_pkg::RST_ZERO8;
      filter_ctrl_q <= motor_gate_pkg::RST_ZERO8;
      pin_func_q <= motor_gate_pkg::RST_PIN_FUNC;
    end else if (access_wr) begin
      case (paddr)
        motor_gate_pkg::OFS_MASK_CTRL: mask_ctrl_q <= pwdata[7:0] & 8'h8f;
        motor_gate_pkg::OFS_MASK_EN: mask_en_q <= pwdata[7:0] & 8'h3f;
        motor_gate_pkg::OFS_MASK_DATA: mask_data_q <= pwdata[7:0] & 8'h3f;
        motor_gate_pkg::OFS_DEAD_TIME: dead_time_q <= pwdata[7:0];
        motor_gate_pkg::OFS_POLARITY: polarity_q <= pwdata[7:0] & 8'h3f;
        motor_gate_pkg::OFS_HALL_CTRL: hall_ctrl_q <= pwdata[7:0] & 8'h1f;
        motor_gate_pkg::OFS_SOFT_HALL: soft_hall_q <= pwdata[7:0] & 8'h07;
        motor_gate_pkg::OFS_FILTER_CTRL: filter_ctrl_q <= pwdata[7:0] & 8'h01;
        motor_gate_pkg::OFS_PIN_FUNC: pin_func_q <= pwdata & 32'h003f3f3f;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < motor_gate_pkg::DECODE_ENTRIES; i++) begin
        decode_table_q[i] <= 6'h00;
      end
    end else if (access_wr && is_table(paddr)) begin
      decode_table_q[table_index(paddr)] <= pwdata[5:0];
    end
  end

  // Commutation word in table order: bit 5 is phase A upper, bit 0 phase C lower.
  logic [5:0] decode_word;
  logic [2:0] step;
  logic [3:0] entry;

  always_comb begin
    step = hall_step(hall_in, hall_ctrl_q[motor_gate_pkg::HC_ANGLE_BIT]);
    entry = {1'b0, step};
    if (hall_ctrl_q[motor_gate_pkg::HC_DIR_BIT]) begin
      entry = 4'(step) + 4'(motor_gate_pkg::FORWARD_ENTRIES);
    end
    if (hall_ctrl_q[motor_gate_pkg::HC_BRAKE_BIT]) begin
      decode_word = motor_gate_pkg::BRAKE_DECODE;
    end else if (!hall_ctrl_q[motor_gate_pkg::HC_DECODER_EN_BIT] || step == 3'h7) begin
      decode_word = 6'h00;
    end else begin
      decode_word = decode_table_q[entry];
    end
  end

  // PWM disabled holds the true term on and the inverted term off, so outputs carry no PWM.
  logic p_eff, pb_eff;
  assign p_eff = mc.pwm_output_enable ? pwm_true_wave : 1'b1;
  assign pb_eff = mc.pwm_output_enable ? pwm_inverted_wave : 1'b0;

  // Output vector order: bit 2n is phase n upper, bit 2n+1 phase n lower.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      logic up, lo, me_u, me_l, md_u, md_l;
      logic [1:0] hw, sw, pair;
      assign up = decode_word[5 - 2 * g];
      assign lo = decode_word[4 - 2 * g];
      assign me_u = mask_en_q[2 * g];
      assign me_l = mask_en_q[2 * g + 1];
      assign md_u = mask_data_q[2 * g];
      assign md_l = mask_data_q[2 * g + 1];
      assign hw = hw_pair(up, lo, mc.top_bottom_pwm_select, mc.hw_complement_select,
                          p_eff, pb_eff);
      always_comb begin
        sw[1] = me_u ? md_u : p_eff;
        sw[0] = me_l ? md_l : pb_eff;
        if (me_u && me_l && md_u && md_l) begin
          sw = 2'b00;
        end
        if (me_u && !me_l) begin
          sw[1] = 1'b0;
        end
        if (!me_u && me_l) begin
          sw[0] = 1'b0;
        end
        pair = mc.mask_mode_select ? sw : hw;
        if (hall_ctrl_q[motor_gate_pkg::HC_BRAKE_BIT]) begin
          pair = 2'b01;
        end else if (protect_active) begin
          pair = {1'b0, mc.protect_output_select};
        end
      end
      assign premask_d[2 * g] = pair[1];
      assign premask_d[2 * g + 1] = pair[0];
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      premask_q <= 6'h00;
    end else begin
      premask_q <= premask_d;
    end
  end

  // The divided dead-time clock is a strobe, so the block stays on one clock.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescale_q <= 3'h0;
    end else begin
      prescale_q <= prescale_q + 3'h1;
    end
  end

  always_comb begin
    case (dt.deadtime_clock_divide)
      2'h0: tick = 1'b1;
      2'h1: tick = prescale_q[0];
      2'h2: tick = &prescale_q[1:0];
      default: tick = &prescale_q;
    endcase
  end

  generate
    for (g = 0; g < 6; g++) begin : g_dead
      dead_time_channel u_dt (
        .clk(clk),
        .reset(reset),
        .tick(tick),
        .enable(dt.deadtime_enable),
        .count(dt.count),
        .din(premask_q[g]),
        .dout(dead_out[g])
      );
    end
  endgenerate

  // Stagger, then polarity, then the pin function select, then the pin register.
  generate
    for (g = 0; g < 3; g++) begin : g_out
      logic both_on;
      assign both_on = dead_out[2 * g] && dead_out[2 * g + 1];
      for (genvar k = 0; k < 2; k++) begin : g_pin
        localparam int N = 2 * g + k;
        logic staggered;
        assign staggered = both_on ? 1'b0 : dead_out[N];
        assign gate_d[N] = pin_func_q[motor_gate_pkg::PF_GPIO_SEL_LSB + N] ?
                           pin_func_q[motor_gate_pkg::PF_GPIO_DATA_LSB + N] :
                           staggered ^ polarity_q[N];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_q <= 6'h00;
      gate_oe <= 6'h00;
    end else begin
      gate_q <= gate_d;
      gate_oe <= pin_func_q[motor_gate_pkg::PF_DRIVE_LSB +: 6];
    end
  end

  assign gate_a_top = gate_q[0];
  assign gate_a_bottom = gate_q[1];
  assign gate_b_top = gate_q[2];
  assign gate_b_bottom = gate_q[3];
  assign gate_c_top = gate_q[4];
  assign gate_c_bottom = gate_q[5];

endmodule // motor_gate_output_stage

// [tb/motor_gate_chk.sv]
// Port-level assertions for the motor gate output stage.
`timescale 1ns/1ps
module motor_gate_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] gate_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic setup;
  assign setup = psel && !penable;
  AST_PREADY_NEXT: assert property (setup |=> pready)
    else $error("pready missing after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_GATED: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_ZERO: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_MON_RO: assert property (
    setup && pwrite && paddr == motor_gate_pkg::OFS_MONITOR |=> pslverr)
    else $error("monitor write accepted");
  AST_MON_HIGH: assert property (
    pready && !pwrite && paddr == motor_gate_pkg::OFS_MONITOR |-> prdata[31:6] == 26'h0)
    else $error("monitor upper bits set");
  AST_UNMAPPED: assert property (
    setup && paddr > motor_gate_pkg::OFS_DECODE_LAST |=> pready && pslverr)
    else $error("unmapped address accepted");
  AST_MAPPED: assert property (
    setup && paddr == motor_gate_pkg::OFS_MASK_CTRL |=> pready && !pslverr)
    else $error("control access refused");
  AST_RST_HIZ: assert property (disable iff (1'b0) reset |-> gate_oe == 6'h00)
    else $error("gate pins driven in reset");
  cover property (setup && pwrite ##1 pready);
  cover property (setup && !pwrite ##1 pready);
  cover property (pslverr);
endmodule // motor_gate_chk

// [tb/gate_bridge_model.sv]
// Gate driver and bridge model seen from the gate pins.
`timescale 1ns/1ps
module gate_bridge_model (
  input wire logic [5:0] gates,
  input wire logic [5:0] oe,
  output logic [5:0] pins,
  output logic [2:0] shoot
);
  // Driver inputs have pull-downs, so an undriven pin reads as transistor off.
  assign pins = gates & oe;
  // Both arms of one pair on would short the supply rail.
  assign shoot = {pins[5] & pins[4], pins[3] & pins[2], pins[1] & pins[0]};
endmodule // gate_bridge_model

// [tb/motor_gate_output_stage_tb_top.sv]
// Self-checking bench for the motor gate output stage.
`timescale 1ns/1ps
module motor_gate_output_stage_tb_top;
  logic clk, reset, psel, penable, pwrite, p, pb, prot, lasterr, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] hall;
  logic [5:0] g, oe, pin;
  int errors, checks_done, n0, n1, x;
  int cyc = 0;
  motor_gate_output_stage motor_gate_output_stage_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_true_wave(p), .pwm_inverted_wave(pb), .protect_active(prot), .hall_pins(hall),
    .gate_a_top(g[0]), .gate_a_bottom(g[1]), .gate_b_top(g[2]), .gate_b_bottom(g[3]),
    .gate_c_top(g[4]), .gate_c_bottom(g[5]), .gate_oe(oe));
  gate_bridge_model gate_bridge_model_i (.gates(g), .oe(oe), .pins(pin), .shoot());
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task end_of_test;
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    lasterr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task settle;
    repeat (12) @(posedge clk);
  endtask
  task wave(input logic a, input logic b);
    @(posedge clk);
    p <= a;
    pb <= b;
    settle;
  endtask
  task meas(input logic v, output int n);
    @(posedge clk);
    p <= v;
    pb <= !v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pin[1] !== v && n < 100);
    settle;
  endtask
  // Decode word 0x1b: phase A 01, phase B 10, phase C 11.
  function logic [5:0] hwexp(input logic [7:0] mc, input logic pp, input logic pq);
    logic t, n, q, r;
    t = mc[0];
    n = mc[3];
    q = mc[2] ? pp : 1'b1;
    r = mc[2] ? pq : 1'b0;
    hwexp = {2'b00, t ? (n ? 1'b0 : r) : 1'b0, t ? q : 1'b1, t ? 1'b1 : q, (t | n) ? 1'b0 : r};
  endfunction
  task t_reset;
    chk({26'h0, pin}, 32'h0);
    rdc(motor_gate_pkg::OFS_MASK_CTRL, 32'h04);
    rdc(motor_gate_pkg::OFS_DEAD_TIME, 32'h0);
    rdc(motor_gate_pkg::OFS_POLARITY, 32'h0);
    rdc(motor_gate_pkg::OFS_MASK_EN, 32'h0);
    rdc(motor_gate_pkg::OFS_MASK_DATA, 32'h0);
    wr(motor_gate_pkg::OFS_MASK_CTRL, 32'hff);
    rdc(motor_gate_pkg::OFS_MASK_CTRL, 32'h8f);
    rdc(8'h70, 32'h0);
    chk(lasterr, 1'b1);
    wr(motor_gate_pkg::OFS_MONITOR, 32'hff);
    chk(lasterr, 1'b1);
  endtask
  task t_hw;
    logic [7:0] mcs [5];
    mcs = '{8'h04, 8'h05, 8'h0c, 8'h0d, 8'h00};
    wr(motor_gate_pkg::OFS_PIN_FUNC, 32'h003f0000);
    wr(motor_gate_pkg::OFS_DECODE_BASE, 32'h1b);
    wr(motor_gate_pkg::OFS_SOFT_HALL, 32'h1);
    wr(motor_gate_pkg::OFS_HALL_CTRL, 32'h11);
    for (int i = 0; i < 5; i++) begin
      wr(motor_gate_pkg::OFS_MASK_CTRL, {24'h0, mcs[i]});
      for (int v = 0; v < 2; v++) begin
        wave(v[0], !v[0]);
        chk({26'h0, pin}, {26'h0, hwexp(mcs[i], v[0], !v[0])});
      end
    end
    wr(motor_gate_pkg::OFS_DECODE_BASE + 8'h18, 32'h24);
    wr(motor_gate_pkg::OFS_HALL_CTRL, 32'h13);
    wr(motor_gate_pkg::OFS_MASK_CTRL, 32'h04);
    wave(1'b1, 1'b0);
    chk({26'h0, pin}, 32'h09);
    wr(motor_gate_pkg::OFS_HALL_CTRL, 32'h11);
  endtask
  task t_sw;
    logic [31:0] rows [5];
    logic [31:0] r;
    rows = '{{8'h80, 8'h3f, 8'h06, 2'b10, 6'h06}, {8'h80, 8'h3f, 8'h03, 2'b10, 6'h00},
      {8'h80, 8'h01, 8'h01, 2'b10, 6'h14}, {8'h84, 8'h00, 8'h00, 2'b11, 6'h00},
      {8'h8c, 8'h00, 8'h00, 2'b01, 6'h2a}};
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      wr(motor_gate_pkg::OFS_MASK_CTRL, {24'h0, r[31:24]});
      wr(motor_gate_pkg::OFS_MASK_EN, {24'h0, r[23:16]});
      wr(motor_gate_pkg::OFS_MASK_DATA, {24'h0, r[15:8]});
      wave(r[7], r[6]);
      chk({26'h0, pin}, {26'h0, r[5:0]});
    end
    wr(motor_gate_pkg::OFS_MASK_EN, 32'h0);
  endtask
  task t_ovr;
    wr(motor_gate_pkg::OFS_MASK_CTRL, 32'h04);
    wave(1'b1, 1'b0);
    @(posedge clk);
    prot <= 1'b1;
    settle;
    chk({26'h0, pin}, 32'h0);
    wr(motor_gate_pkg::OFS_MASK_CTRL, 32'h06);
    settle;
    chk({26'h0, pin}, 32'h2a);
    wr(motor_gate_pkg::OFS_MASK_CTRL, 32'h04);
    wr(motor_gate_pkg::OFS_HALL_CTRL, 32'h15);
    settle;
    chk({26'h0, pin}, 32'h2a);
    @(posedge clk);
    prot <= 1'b0;
    settle;
    chk({26'h0, pin}, 32'h2a);
    wr(motor_gate_pkg::OFS_HALL_CTRL, 32'h11);
  endtask
  task t_dead;
    logic [23:0] tab [6];
    tab = '{{8'h23, 8'd4, 8'd4}, {8'h3f, 8'd32, 8'd32}, {8'h21, 8'd2, 8'd2},
      {8'h61, 8'd3, 8'd4}, {8'ha1, 8'd5, 8'd8}, {8'he1, 8'd9, 8'd16}};
    wave(1'b0, 1'b1);
    wr(motor_gate_pkg::OFS_DEAD_TIME, 32'h03);
    meas(1'b1, n0);
    meas(1'b0, n1);
    chk(n1, n0);
    for (int i = 0; i < 6; i++) begin
      wr(motor_gate_pkg::OFS_DEAD_TIME, {24'h0, tab[i][23:16]});
      meas(1'b1, n1);
      chk(n1 - n0 >= tab[i][15:8] && n1 - n0 <= tab[i][7:0], 1'b1);
      meas(1'b0, x);
      chk(x, n0);
    end
    wr(motor_gate_pkg::OFS_DEAD_TIME, 32'h0);
  endtask
  task t_pol;
    wave(1'b1, 1'b0);
    wr(motor_gate_pkg::OFS_POLARITY, 32'h3f);
    rdc(motor_gate_pkg::OFS_POLARITY, 32'h3f);
    settle;
    chk({26'h0, pin}, 32'h39);
    wr(motor_gate_pkg::OFS_PIN_FUNC, 32'h003f0001);
    settle;
    chk({26'h0, pin}, 32'h38);
    wr(motor_gate_pkg::OFS_PIN_FUNC, 32'h0);
    settle;
    chk({26'h0, pin}, 32'h0);
    wr(motor_gate_pkg::OFS_PIN_FUNC, 32'h003f0000);
    wr(motor_gate_pkg::OFS_POLARITY, 32'h0);
  endtask
  task t_hall;
    wr(motor_gate_pkg::OFS_FILTER_CTRL, 32'h0);
    @(posedge clk);
    hall <= 3'b101;
    // Read before the filter could have followed, so only the bypass shows the new level.
    repeat (5) @(posedge clk);
    rdc(motor_gate_pkg::OFS_MONITOR, {26'h0, pin[0], pin[1], pin[2], 3'b101});
    wr(motor_gate_pkg::OFS_HALL_CTRL, 32'h19);
    @(posedge clk);
    hall <= 3'b001;
    settle;
    chk({26'h0, pin}, {26'h0, hwexp(8'h04, 1'b1, 1'b0)});
    @(posedge clk);
    hall <= 3'b011;
    settle;
    chk({26'h0, pin}, 32'h0);
    wr(motor_gate_pkg::OFS_FILTER_CTRL, 32'h1);
    @(posedge clk);
    hall <= 3'b100;
    repeat (5) @(posedge clk);
    rdc(motor_gate_pkg::OFS_MONITOR, 32'h03);
  endtask
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, p, pb, prot, lasterr} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    hall = 3'b000;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_hw;
    t_sw;
    t_ovr;
    t_dead;
    t_pol;
    t_hall;
    end_of_test;
  end
endmodule // motor_gate_output_stage_tb_top
bind motor_gate_output_stage motor_gate_chk motor_gate_chk_i (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gate_oe(gate_oe));
